/* File: verilog/scsa_map.svh */
// register map, field positions, reset values and counts of the status and sysref block
// assumes nothing; included by the package and by every design file
`ifndef SCSA_MAP_SVH
`define SCSA_MAP_SVH

// ==========================================================================
// register addresses (7-bit serial address space)
`define SCSA_ADDR_CTRL 7'h00
`define SCSA_ADDR_INIT 7'h01
`define SCSA_ADDR_SREF 7'h02
`define SCSA_ADDR_SYSREF_PULSE_COUNT 7'h03
`define SCSA_ADDR_SRDIV 7'h04
`define SCSA_ADDR_CKDIV 7'h05
`define SCSA_ADDR_MST 7'h06
`define SCSA_ADDR_LST 7'h07
`define SCSA_ADDR_IEN 7'h08
`define SCSA_ADDR_OEN1 7'h74
`define SCSA_ADDR_OEN2 7'h76

// ==========================================================================
// control register fields
`define SCSA_CTRL_RDEDGE 0
`define SCSA_CTRL_VCXO_PLL_BYPASS 1
`define SCSA_CTRL_SYNTH_FEEDBACK_BYPASS 2
`define SCSA_CTRL_FORCE_VCXO_CENTER 3
`define SCSA_CTRL_MODE_LO 4
`define SCSA_CTRL_MODE_HI 5
`define SCSA_REF_MANUAL 2'h0
`define SCSA_REF_SHORT_HOLD 2'h1
`define SCSA_REF_AUTO_HOLD 2'h2
`define SCSA_REF_AUTO 2'h3

// init register fields
`define SCSA_INIT_DIV 0
`define SCSA_INIT_REQUEST_A 1
`define SCSA_INIT_BANDCAL 2

// sysref register fields
`define SCSA_SREF_SRC 0
`define SCSA_SREF_MODE 1
`define SCSA_SREF_REL 2
`define SCSA_SREF_ARMED 3
`define SCSA_SREF_RUN 4

// status bit positions
`define SCSA_ST_VCXO 0
`define SCSA_ST_SYNTH 1
`define SCSA_ST_REF 2
`define SCSA_ST_W 3

// ==========================================================================
// reset values
`define SCSA_RST_CTRL 8'h08
`define SCSA_RST_SYSREF_PULSE_COUNT 8'h01
`define SCSA_RST_SRDIV 8'h04
`define SCSA_RST_CKDIV 8'h01
`define SCSA_RST_IEN 3'h0
`define SCSA_RST_OEN 8'h00
`define SCSA_RST_SYNC 9'h002

// ==========================================================================
// counts and widths
`define SCSA_INIT_CYCLES 8'h08
`define SCSA_NOUT 8
`define SCSA_BIT_LAST 3'h7

// synchroniser lanes
`define SCSA_SYNC_W 9
`define SCSA_SY_SCLK 0
`define SCSA_SY_CSN 1
`define SCSA_SY_SDAT 2
`define SCSA_SY_EXT 3
`define SCSA_SY_VCXO 4
`define SCSA_SY_SYNTH 5
`define SCSA_SY_SELLOST 6
`define SCSA_SY_ANYVALID 7
`define SCSA_SY_HOLD 8

`endif

/* File: verilog/scsa_pkg.sv */
// types shared by the status and sysref block
// assumes scsa_map.svh is on the include path
`include "scsa_map.svh"

package scsa_pkg;

  // ==========================================================================
  // enumerations
  typedef enum logic [1:0] {SR_IDLE, SR_ARMED, SR_RUN} scsa_sr_state_type;
  typedef enum logic [1:0] {SPI_HDR, SPI_WR, SPI_RD} scsa_spi_state_type;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
    logic [7:0] data;
  } scsa_wr_type;

  typedef struct packed {
    logic [`SCSA_SYNC_W-1:0] s1;
    logic [`SCSA_SYNC_W-1:0] s2;
    logic [`SCSA_SYNC_W-1:0] s3;
    logic [`SCSA_SYNC_W-1:0] q;
  } scsa_sync_type;

  typedef struct packed {
    scsa_spi_state_type state;
    logic [2:0] bitcnt;
    logic [7:0] shift;
    logic [6:0] addr;
    logic load;
    logic sclk_prev;
    logic sdat;
    logic sdat_oe;
    scsa_wr_type wr;
  } scsa_spi_type;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] init_cnt;
    logic request_a_p;
    logic bandcal_p;
    logic sr_src;
    logic sr_mode;
    logic sr_rel;
    logic [7:0] sysref_pulse_count;
    logic [7:0] srdiv;
    logic [7:0] ckdiv;
    logic [`SCSA_ST_W-1:0] latched;
    logic [`SCSA_ST_W-1:0] ien;
    logic [7:0] oen1;
    logic [7:0] oen2;
    scsa_sr_state_type sr_state;
    logic [7:0] ck_cnt;
    logic ck_phase;
    logic [7:0] sr_cnt;
    logic sr_level;
    logic [7:0] pulses_left;
    logic ext_prev;
    logic [`SCSA_NOUT-1:0] clk_out;
    logic [`SCSA_NOUT-1:0] sref_out;
    logic int_n;
    logic lock;
  } scsa_core_type;

endpackage

/* File: verilog/scsa_sync.sv */
// three-flop synchroniser for every pin that enters from outside the clock
// assumes pins are asynchronous to sys_clk_i; a change passes once stages two and three agree
`timescale 1ns/100ps
`include "scsa_map.svh"

module scsa_sync (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [`SCSA_SYNC_W-1:0] pins_i,
  output logic [`SCSA_SYNC_W-1:0] sync_o
);

  scsa_pkg::scsa_sync_type r;
  scsa_pkg::scsa_sync_type next_r;

  // ==========================================================================
  // next state
  always_comb begin
    next_r = r;
    next_r.s1 = pins_i;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.q = (r.s2 & r.s3) | (r.q & (r.s2 ^ r.s3));
  end

  // ==========================================================================
  // registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      r.s1 <= `SCSA_RST_SYNC;
      r.s2 <= `SCSA_RST_SYNC;
      r.s3 <= `SCSA_RST_SYNC;
      r.q <= `SCSA_RST_SYNC;
    end else begin
      r <= next_r;
    end
  end

  assign sync_o = r.q;

endmodule

/* File: verilog/scsa_spi.sv */
// 3-wire serial register port: header byte (direction, address lsb first), then data bytes
// assumes sclk, cs_n and sdat arrive already synchronised; sclk much slower than sys_clk_i
`timescale 1ns/100ps
`include "scsa_map.svh"

module scsa_spi (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic sdat_i,
  input wire logic read_edge_select_i,
  input wire logic [7:0] rd_data_i,
  output logic [6:0] rd_addr_o,
  output scsa_pkg::scsa_wr_type wr_o,
  output logic sdat_o,
  output logic sdat_oe_o
);

  scsa_pkg::scsa_spi_type r;
  scsa_pkg::scsa_spi_type next_r;
  logic rise;
  logic fall;
  logic out_edge;
  logic [7:0] shin;

  // ==========================================================================
  // next state
  always_comb begin
    next_r = r;
    rise = sclk_i & ~r.sclk_prev;
    fall = ~sclk_i & r.sclk_prev;
    out_edge = read_edge_select_i ? rise : fall;
    shin = {sdat_i, r.shift[7:1]};
    next_r.sclk_prev = sclk_i;
    next_r.wr.valid = 1'h0;
    next_r.load = 1'h0;
    if (cs_n_i) begin
      next_r.state = scsa_pkg::SPI_HDR;
      next_r.bitcnt = 3'h0;
      next_r.sdat_oe = 1'h0;
    end else begin
      case (r.state)
        scsa_pkg::SPI_HDR: begin
          if (rise) begin
            next_r.shift = shin;
            next_r.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == `SCSA_BIT_LAST) begin
              next_r.addr = shin[7:1];
              next_r.load = shin[0];
              next_r.state = shin[0] ? scsa_pkg::SPI_RD : scsa_pkg::SPI_WR;
            end
          end
        end
        scsa_pkg::SPI_WR: begin
          if (rise) begin
            next_r.shift = shin;
            next_r.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == `SCSA_BIT_LAST) begin
              next_r.wr.valid = 1'h1;
              next_r.wr.addr = r.addr;
              next_r.wr.data = shin;
              next_r.addr = r.addr + 7'h01;
            end
          end
        end
        scsa_pkg::SPI_RD: begin
          if (r.load) begin
            // register content captured once the address has settled
            next_r.shift = rd_data_i;
            next_r.sdat_oe = 1'h1;
          end else if (out_edge) begin
            next_r.sdat = r.shift[0];
            next_r.shift = {1'h0, r.shift[7:1]};
            next_r.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == `SCSA_BIT_LAST) begin
              next_r.addr = r.addr + 7'h01;
              next_r.load = 1'h1;
            end
          end
        end
        default: begin
          next_r.state = scsa_pkg::SPI_HDR;
        end
      endcase
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      r.state <= scsa_pkg::SPI_HDR;
      r.bitcnt <= 3'h0;
      r.shift <= 8'h00;
      r.addr <= 7'h00;
      r.load <= 1'h0;
      r.sclk_prev <= 1'h0;
      r.sdat <= 1'h0;
      r.sdat_oe <= 1'h0;
      r.wr <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rd_addr_o = r.addr;
  assign wr_o = r.wr;
  assign sdat_o = r.sdat;
  assign sdat_oe_o = r.sdat_oe;

endmodule

/* File: verilog/scsa_top.sv */
// status, interrupt and sysref arming control of a dual-pll clock conditioner
// assumes one 20 MHz clock, a synchronous active-high power-on reset, and a 3-wire serial host
//
// How it works
// - source select 1 starts on sync rising edge
// - external trigger honours pulse mode and count
// - sysref phase independent of trigger source
// - momentary status reads live, never latched
// - latched status sticks until written one
// - clear ineffective while condition persists
// - interrupt enable zero masks latched bit
// - interrupt low while any enabled bit set
// - vcxo bypass removes vcxo lock from lock pin
// - reference status encoding depends on input mode
// - reset loads defaults, outputs start disabled
// - vcxo held centred until force bit cleared
// - divider init restarts clock divider, stops a running sysref, self clears
// - outputs forced low during divider init
// - request_a and calibration bits self clear
// - bypass bits steer feedback for deterministic delay
// - release in counted mode loads count, emits pulses
// - continuous mode free runs, count ignored
`timescale 1ns/100ps
`include "scsa_map.svh"

module scsa_top (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic spi_sclk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_sdat_i,
  output logic spi_sdat_o,
  output logic spi_sdat_oe_o,
  input wire logic external_sync_input_i,
  input wire logic vcxo_lock_i,
  input wire logic synth_lock_i,
  input wire logic ref_sel_lost_i,
  input wire logic ref_any_valid_i,
  input wire logic holdover_active_i,
  output logic [`SCSA_NOUT-1:0] clock_output_o,
  output logic [`SCSA_NOUT-1:0] sysref_output_o,
  output logic interrupt_out_n_o,
  output logic lock_o,
  output logic force_vcxo_center_o,
  output logic vcxo_pll_bypass_o,
  output logic synth_feedback_bypass_o,
  output logic divider_init_o,
  output logic request_a_o,
  output logic band_calibration_o
);

  scsa_pkg::scsa_core_type r;
  scsa_pkg::scsa_core_type next_r;
  scsa_pkg::scsa_wr_type wr;
  logic [`SCSA_SYNC_W-1:0] pins;
  logic [`SCSA_SYNC_W-1:0] sy;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  logic [`SCSA_ST_W-1:0] mst;
  logic ref_ok;
  logic busy;
  logic ck_tick;
  logic ck_rise;
  logic ext_rise;
  logic rel_write;
  logic start;

  // ==========================================================================
  // pin synchronisation
  always_comb begin
    pins = '0;
    pins[`SCSA_SY_SCLK] = spi_sclk_i;
    pins[`SCSA_SY_CSN] = spi_cs_n_i;
    pins[`SCSA_SY_SDAT] = spi_sdat_i;
    pins[`SCSA_SY_EXT] = external_sync_input_i;
    pins[`SCSA_SY_VCXO] = vcxo_lock_i;
    pins[`SCSA_SY_SYNTH] = synth_lock_i;
    pins[`SCSA_SY_SELLOST] = ref_sel_lost_i;
    pins[`SCSA_SY_ANYVALID] = ref_any_valid_i;
    pins[`SCSA_SY_HOLD] = holdover_active_i;
  end

  scsa_sync u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pins_i(pins),
    .sync_o(sy)
  );

  // ==========================================================================
  // serial register port
  scsa_spi u_spi (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .sclk_i(sy[`SCSA_SY_SCLK]),
    .cs_n_i(sy[`SCSA_SY_CSN]),
    .sdat_i(sy[`SCSA_SY_SDAT]),
    .read_edge_select_i(r.ctrl[`SCSA_CTRL_RDEDGE]),
    .rd_data_i(rd_data),
    .rd_addr_o(rd_addr),
    .wr_o(wr),
    .sdat_o(spi_sdat_o),
    .sdat_oe_o(spi_sdat_oe_o)
  );

  // ==========================================================================
  // live status
  always_comb begin
    case (r.ctrl[`SCSA_CTRL_MODE_HI:`SCSA_CTRL_MODE_LO])
      `SCSA_REF_MANUAL: ref_ok = ~sy[`SCSA_SY_SELLOST];
      `SCSA_REF_SHORT_HOLD: ref_ok = ~sy[`SCSA_SY_SELLOST];
      `SCSA_REF_AUTO_HOLD: ref_ok = sy[`SCSA_SY_ANYVALID] & ~sy[`SCSA_SY_HOLD];
      default: ref_ok = sy[`SCSA_SY_ANYVALID];
    endcase
    mst = '0;
    mst[`SCSA_ST_VCXO] = sy[`SCSA_SY_VCXO];
    mst[`SCSA_ST_SYNTH] = sy[`SCSA_SY_SYNTH];
    mst[`SCSA_ST_REF] = ref_ok;
  end

  // ==========================================================================
  // register read
  always_comb begin
    rd_data = 8'h00;
    case (rd_addr)
      `SCSA_ADDR_CTRL: rd_data = r.ctrl;
      `SCSA_ADDR_INIT: rd_data[`SCSA_INIT_DIV] = busy;
      `SCSA_ADDR_SREF: begin
        rd_data[`SCSA_SREF_SRC] = r.sr_src;
        rd_data[`SCSA_SREF_MODE] = r.sr_mode;
        rd_data[`SCSA_SREF_REL] = r.sr_rel;
        rd_data[`SCSA_SREF_ARMED] = r.sr_state == scsa_pkg::SR_ARMED;
        rd_data[`SCSA_SREF_RUN] = r.sr_state == scsa_pkg::SR_RUN;
      end
      `SCSA_ADDR_SYSREF_PULSE_COUNT: rd_data = r.sysref_pulse_count;
      `SCSA_ADDR_SRDIV: rd_data = r.srdiv;
      `SCSA_ADDR_CKDIV: rd_data = r.ckdiv;
      `SCSA_ADDR_MST: rd_data[`SCSA_ST_W-1:0] = mst;
      `SCSA_ADDR_LST: rd_data[`SCSA_ST_W-1:0] = r.latched;
      `SCSA_ADDR_IEN: rd_data[`SCSA_ST_W-1:0] = r.ien;
      `SCSA_ADDR_OEN1: rd_data = r.oen1;
      `SCSA_ADDR_OEN2: rd_data = r.oen2;
      default: rd_data = 8'h00;
    endcase
  end

  // ==========================================================================
  // next state
  always_comb begin
    next_r = r;
    busy = r.init_cnt != 8'h00;
    next_r.request_a_p = 1'h0;
    next_r.bandcal_p = 1'h0;
    if (busy) begin
      next_r.init_cnt = r.init_cnt - 8'h01;
    end
    rel_write = 1'h0;
    next_r.latched = r.latched;
    if (wr.valid) begin
      case (wr.addr)
        `SCSA_ADDR_CTRL: next_r.ctrl = wr.data;
        `SCSA_ADDR_INIT: begin
          if (wr.data[`SCSA_INIT_DIV]) begin
            next_r.init_cnt = `SCSA_INIT_CYCLES;
          end
          next_r.request_a_p = wr.data[`SCSA_INIT_REQUEST_A];
          next_r.bandcal_p = wr.data[`SCSA_INIT_BANDCAL];
        end
        `SCSA_ADDR_SREF: begin
          next_r.sr_src = wr.data[`SCSA_SREF_SRC];
          next_r.sr_mode = wr.data[`SCSA_SREF_MODE];
          rel_write = wr.data[`SCSA_SREF_REL];
          if (rel_write) begin
            next_r.sr_rel = 1'h1;
          end
        end
        `SCSA_ADDR_SYSREF_PULSE_COUNT: next_r.sysref_pulse_count = wr.data;
        `SCSA_ADDR_SRDIV: next_r.srdiv = wr.data;
        `SCSA_ADDR_CKDIV: next_r.ckdiv = wr.data;
        `SCSA_ADDR_LST: next_r.latched = r.latched & ~wr.data[`SCSA_ST_W-1:0];
        `SCSA_ADDR_IEN: next_r.ien = wr.data[`SCSA_ST_W-1:0];
        `SCSA_ADDR_OEN1: next_r.oen1 = wr.data;
        `SCSA_ADDR_OEN2: next_r.oen2 = wr.data;
        default: next_r.ctrl = r.ctrl;
      endcase
    end
    // a persisting fault sets the bit again, winning over the clear
    next_r.latched = next_r.latched | ~mst;
    next_r.int_n = ~|(next_r.latched & r.ien);
    next_r.lock = sy[`SCSA_SY_SYNTH]
      & (r.ctrl[`SCSA_CTRL_VCXO_PLL_BYPASS] | sy[`SCSA_SY_VCXO]);

    // clock divider, the only timebase for both clock and sysref edges
    ck_tick = r.ck_cnt >= r.ckdiv;
    ck_rise = ck_tick & ~r.ck_phase;
    if (busy) begin
      next_r.ck_cnt = 8'h00;
      next_r.ck_phase = 1'h0;
    end else if (ck_tick) begin
      next_r.ck_cnt = 8'h00;
      next_r.ck_phase = ~r.ck_phase;
    end else begin
      next_r.ck_cnt = r.ck_cnt + 8'h01;
    end

    // sysref sequencer
    ext_rise = sy[`SCSA_SY_EXT] & ~r.ext_prev;
    next_r.ext_prev = sy[`SCSA_SY_EXT];
    start = 1'h0;
    case (r.sr_state)
      scsa_pkg::SR_IDLE: begin
        next_r.sr_level = 1'h0;
        if (r.sr_rel) begin
          if (r.sr_src) begin
            next_r.sr_state = scsa_pkg::SR_ARMED;
          end else begin
            start = 1'h1;
          end
        end
      end
      scsa_pkg::SR_ARMED: begin
        if (!r.sr_src) begin
          start = 1'h1;
        end else if (ext_rise) begin
          start = 1'h1;
        end
      end
      scsa_pkg::SR_RUN: begin
        if (ck_rise) begin
          if (r.sr_cnt >= r.srdiv) begin
            next_r.sr_cnt = 8'h00;
            next_r.sr_level = ~r.sr_level;
            if (r.sr_level && !r.sr_mode) begin
              next_r.pulses_left = r.pulses_left - 8'h01;
              if (r.pulses_left == 8'h01) begin
                next_r.sr_state = scsa_pkg::SR_IDLE;
              end
            end
          end else begin
            next_r.sr_cnt = r.sr_cnt + 8'h01;
          end
        end
      end
      default: begin
        next_r.sr_state = scsa_pkg::SR_IDLE;
      end
    endcase
    if (start) begin
      if (!rel_write) begin
        next_r.sr_rel = 1'h0;
      end
      next_r.pulses_left = r.sysref_pulse_count;
      next_r.sr_cnt = 8'h00;
      next_r.sr_level = 1'h0;
      if (!r.sr_mode && r.sysref_pulse_count == 8'h00) begin
        next_r.sr_state = scsa_pkg::SR_IDLE;
      end else begin
        next_r.sr_state = scsa_pkg::SR_RUN;
      end
    end
    if (busy && r.sr_state == scsa_pkg::SR_RUN) begin
      next_r.sr_state = scsa_pkg::SR_IDLE;
      next_r.sr_level = 1'h0;
    end

    // output gating: enable register and init blanking
    next_r.clk_out = (next_r.init_cnt != 8'h00) ? '0
      : (r.oen1 & {`SCSA_NOUT{next_r.ck_phase}});
    next_r.sref_out = (next_r.init_cnt != 8'h00) ? '0
      : (r.oen2 & {`SCSA_NOUT{next_r.sr_level}});
  end

  // ==========================================================================
  // registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      r.ctrl <= `SCSA_RST_CTRL;
      r.init_cnt <= 8'h00;
      r.request_a_p <= 1'h0;
      r.bandcal_p <= 1'h0;
      r.sr_src <= 1'h0;
      r.sr_mode <= 1'h0;
      r.sr_rel <= 1'h0;
      r.sysref_pulse_count <= `SCSA_RST_SYSREF_PULSE_COUNT;
      r.srdiv <= `SCSA_RST_SRDIV;
      r.ckdiv <= `SCSA_RST_CKDIV;
      r.latched <= '0;
      r.ien <= `SCSA_RST_IEN;
      r.oen1 <= `SCSA_RST_OEN;
      r.oen2 <= `SCSA_RST_OEN;
      r.sr_state <= scsa_pkg::SR_IDLE;
      r.ck_cnt <= 8'h00;
      r.ck_phase <= 1'h0;
      r.sr_cnt <= 8'h00;
      r.sr_level <= 1'h0;
      r.pulses_left <= 8'h00;
      r.ext_prev <= 1'h0;
      r.clk_out <= '0;
      r.sref_out <= '0;
      r.int_n <= 1'h1;
      r.lock <= 1'h0;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // outputs
  assign clock_output_o = r.clk_out;
  assign sysref_output_o = r.sref_out;
  assign interrupt_out_n_o = r.int_n;
  assign lock_o = r.lock;
  assign force_vcxo_center_o = r.ctrl[`SCSA_CTRL_FORCE_VCXO_CENTER];
  assign vcxo_pll_bypass_o = r.ctrl[`SCSA_CTRL_VCXO_PLL_BYPASS];
  assign synth_feedback_bypass_o = r.ctrl[`SCSA_CTRL_SYNTH_FEEDBACK_BYPASS];
  assign divider_init_o = r.init_cnt != 8'h00;
  assign request_a_o = r.request_a_p;
  assign band_calibration_o = r.bandcal_p;

endmodule

/* File: verif/scsa_chk.sv */
// port checks of the status and sysref block
// assumes scsa_map.svh on the include path; bound into scsa_top at the foot
`timescale 1ns/100ps
`include "scsa_map.svh"
module scsa_chk (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic spi_cs_n_i,
  input wire logic vcxo_lock_i,
  input wire logic synth_lock_i,
  input wire logic [`SCSA_NOUT-1:0] clock_output_o,
  input wire logic [`SCSA_NOUT-1:0] sysref_output_o,
  input wire logic interrupt_out_n_o,
  input wire logic lock_o,
  input wire logic force_vcxo_center_o,
  input wire logic vcxo_pll_bypass_o,
  input wire logic divider_init_o,
  input wire logic request_a_o,
  input wire logic band_calibration_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // assertions
  a_reset_vals: assert property (
    $fell(rst_i) |-> force_vcxo_center_o && interrupt_out_n_o && !lock_o
    && !(|{clock_output_o, sysref_output_o})) else $error("bad reset state");
  a_init_low: assert property (
    divider_init_o && $past(divider_init_o) |-> !(|{clock_output_o, sysref_output_o}))
    else $error("output high in init");
  a_init_len: assert property (
    $rose(divider_init_o) |-> divider_init_o [*8] ##1 !divider_init_o) else $error("init length");
  a_request_a_pulse: assert property (
    request_a_o |=> !request_a_o) else $error("request_a not pulse");
  a_cal_pulse: assert property (
    band_calibration_o |=> !band_calibration_o) else $error("cal not pulse");
  a_lock_on: assert property (
    (synth_lock_i && (vcxo_lock_i || vcxo_pll_bypass_o)) [*8] |-> lock_o) else $error("lock low");
  a_lock_off: assert property (
    (!synth_lock_i || (!vcxo_lock_i && !vcxo_pll_bypass_o)) [*8] |-> !lock_o)
    else $error("lock high");
  a_ctrl_hold: assert property (
    spi_cs_n_i [*8] |=> $stable({force_vcxo_center_o, vcxo_pll_bypass_o}))
    else $error("ctrl changed idle");
  c_init: cover property ($rose(divider_init_o));
  c_sref: cover property ($rose(sysref_output_o[0]));
  c_irq: cover property ($fell(interrupt_out_n_o));
endmodule
bind scsa_top scsa_chk u_chk (.sys_clk_i, .rst_i, .spi_cs_n_i, .vcxo_lock_i, .synth_lock_i,
  .clock_output_o, .sysref_output_o, .interrupt_out_n_o, .lock_o, .force_vcxo_center_o,
  .vcxo_pll_bypass_o, .divider_init_o, .request_a_o, .band_calibration_o);

/* File: verif/scsa_host.sv */
// serial host: header then one data byte, lsb first, 8 clocks each half period
// assumes the bench clock paces it; pins change at its falling edge
`timescale 1ns/100ps
module scsa_host (
  input wire logic sys_clk_i,
  input wire logic sdat_i,
  input wire logic sdat_oe_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic wire_o
);
  logic hd = 1'b0;
  logic hen = 1'b1;
  // read edge select last written: 1 means sample after the rising edge
  logic rde = 1'b0;
  // released wire shows the inverse of the last driven bit
  assign wire_o = sdat_oe_i ? sdat_i : (hen ? hd : ~hd);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
  end
  task automatic hp();
    repeat (8) @(negedge sys_clk_i);
  endtask
  task automatic put(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      hd = b[i];
      hp();
      sclk_o = 1'b1;
      hp();
      sclk_o = 1'b0;
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    cs_n_o = 1'b0;
    hen = 1'b1;
    hp();
    put({a, 1'b0});
    put(d);
    hp();
    cs_n_o = 1'b1;
    if (a == 7'h00) rde = d[0];
    repeat (3) hp();
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    cs_n_o = 1'b0;
    hen = 1'b1;
    hp();
    put({a, 1'b1});
    hen = 1'b0;
    for (int i = 0; i < 8; i++) begin
      hp();
      if (!rde) d[i] = wire_o;
      sclk_o = 1'b1;
      hp();
      if (rde) d[i] = wire_o;
      sclk_o = 1'b0;
    end
    hp();
    cs_n_o = 1'b1;
    repeat (3) hp();
  endtask
endmodule

/* File: verif/scsa_top_tb.sv */
// self-checking bench of the status and sysref block against a register model
// assumes scsa_pkg, scsa_chk and scsa_host are compiled before it
`timescale 1ns/100ps
module scsa_top_tb;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sclk, csn, sdat, sdo, soe, ext = 1'b0, vl = 1'b0, sl = 1'b0, rl = 1'b0, av = 1'b0;
  logic int_n, lock, fvc, vcxo_pll_bypass, synth_feedback_bypass, dinit, rq, cal, ro, ho = 1'b0;
  logic [7:0] ck, sr, n, m [0:127];
  logic [1:0] md [$] = '{2'h0, 2'h1, 2'h2, 2'h3};
  logic [6:0] ra [$] = '{7'h00, 7'h03, 7'h04, 7'h05, 7'h08, 7'h74, 7'h76, 7'h7A};
  int failures = 0, cmp_count = 0, pc = 0, rq_n = 0, cal_n = 0, cyc = 0, dn = 0;
  scsa_top uut (.sys_clk_i, .rst_i, .spi_sclk_i(sclk), .spi_cs_n_i(csn), .spi_sdat_i(sdat),
    .spi_sdat_o(sdo), .spi_sdat_oe_o(soe), .external_sync_input_i(ext), .vcxo_lock_i(vl),
    .synth_lock_i(sl), .ref_sel_lost_i(rl), .ref_any_valid_i(av), .holdover_active_i(ho),
    .clock_output_o(ck), .sysref_output_o(sr), .interrupt_out_n_o(int_n), .lock_o(lock),
    .force_vcxo_center_o(fvc), .vcxo_pll_bypass_o(vcxo_pll_bypass), .synth_feedback_bypass_o(synth_feedback_bypass),
    .divider_init_o(dinit), .request_a_o(rq), .band_calibration_o(cal));
  scsa_host u_host (.sys_clk_i, .sdat_i(sdo), .sdat_oe_i(soe), .sclk_o(sclk), .cs_n_o(csn),
    .wire_o(sdat));
  initial forever #25 sys_clk_i = ~sys_clk_i;
  always @(posedge sr[0]) pc++;
  always @(posedge rq) rq_n++;
  always @(posedge cal) cal_n++;
  always @(negedge sys_clk_i) if (dinit === 1'b1) dn++;
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.wr(a, d);
    m[a] = d;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk("register", d, e);
  endtask
  task automatic wt(input int c);
    repeat (c) @(negedge sys_clk_i);
  endtask
  task automatic pulse();
    ext = 1'b1;
    wt(10);
    ext = 1'b0;
    wt(600);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    void'($urandom(82839));
    m = '{default: 8'h00};
    m[0] = 8'h08;
    m[3] = 8'h01;
    m[4] = 8'h04;
    m[5] = 8'h01;
    wt(5);
    rst_i = 1'b0;
    wt(4);
    chk("reset pins", ck | sr, 8'h00);
    chk("reset flags", {5'h00, int_n, fvc, lock}, 8'h06);
    foreach (ra[i]) rd(ra[i], m[ra[i]]);
    done("reset");
    foreach (md[j]) begin
      wr(7'h00, {2'h0, md[j], 4'h8});
      repeat (2) begin
        {vl, sl, rl, av, ho} = 5'($urandom());
        wt(8);
        ro = (md[j] == 2'h3) ? av : ((md[j] == 2'h2) ? (av & ~ho) : ~rl);
        rd(7'h06, {5'h00, ro, sl, vl});
      end
    end
    done("status");
    wr(7'h00, 8'h39);
    {vl, sl, rl, av, ho} = 5'h0A;
    wt(8);
    wr(7'h07, 8'h07);
    rd(7'h07, 8'h01);
    wr(7'h08, 8'h01);
    chk("irq on", {7'h00, int_n}, 8'h00);
    wr(7'h08, 8'h00);
    chk("irq masked", {7'h00, int_n}, 8'h01);
    wr(7'h08, 8'h01);
    vl = 1'b1;
    wt(8);
    chk("irq sticky", {7'h00, int_n}, 8'h00);
    wr(7'h07, 8'h01);
    rd(7'h07, 8'h00);
    chk("irq off", {7'h00, int_n}, 8'h01);
    done("irq");
    vl = 1'b0;
    wt(8);
    chk("ctrl pins", {4'h0, fvc, vcxo_pll_bypass, synth_feedback_bypass, lock}, 8'h08);
    wr(7'h00, 8'h36);
    chk("ctrl pins", {4'h0, fvc, vcxo_pll_bypass, synth_feedback_bypass, lock}, 8'h07);
    done("lock");
    wr(7'h74, 8'hFF);
    wr(7'h76, 8'hFF);
    wr(7'h05, 8'h02);
    rd(7'h05, m[5]);
    wr(7'h01, 8'h01);
    chk("init length", 8'(dn), 8'h08);
    rd(7'h01, 8'h00);
    wr(7'h01, 8'h06);
    chk("pulses", {rq_n[3:0], cal_n[3:0]}, 8'h11);
    done("init");
    n = 8'(1 + $urandom() % 4);
    wr(7'h03, n);
    pc = 0;
    wr(7'h02, 8'h04);
    wt(600);
    chk("counted", 8'(pc), n);
    pc = 0;
    wr(7'h02, 8'h06);
    wt(600);
    chk("continuous", {7'h00, pc > 4}, 8'h01);
    wr(7'h01, 8'h01);
    wt(20);
    pc = 0;
    wr(7'h02, 8'h01);
    pulse();
    chk("unarmed", 8'(pc), 8'h00);
    wr(7'h02, 8'h05);
    pulse();
    pulse();
    chk("triggered", 8'(pc), n);
    done("sysref");
    rst_i = 1'b1;
    wt(2);
    rst_i = 1'b0;
    wt(4);
    chk("restart pins", ck | sr, 8'h00);
    rd(7'h76, 8'h00);
    done("restart");
    finish_test();
  end
endmodule
